// [design/cpic_pkg.sv]
// Purpose: shared constants, carriers and helpers of the cascaded
//          priority request controller pair
// Assumes: 8-bit I/O port space, one 100 MHz clock
// Notes:   vector bases and the extra port offsets are plain defaults
package cpic_pkg;

   // i/o port map
   localparam logic [7:0] PRI_CMD_PORT  = 8'h20;
   localparam logic [7:0] PRI_MASK_PORT = 8'h21;
   localparam logic [7:0] PRI_TRIG_PORT = 8'h22;
   localparam logic [7:0] SEC_CMD_PORT  = 8'hA0;
   localparam logic [7:0] SEC_MASK_PORT = 8'hA1;
   localparam logic [7:0] SEC_TRIG_PORT = 8'hA2;

   // reset values and codes
   localparam logic [7:0] MASK_RESET    = 8'hFF;
   localparam logic [7:0] TRIG_RESET    = 8'h00;
   localparam logic [7:0] ISR_RESET     = 8'h00;
   localparam logic [7:0] VEC_RESET     = 8'h00;
   localparam logic [7:0] SERVICE_DONE  = 8'h20;
   localparam logic [7:0] UNMAPPED_READ = 8'hFF;
   localparam logic [2:0] CASCADE_LINE  = 3'h2;
   localparam logic [2:0] SPURIOUS_LINE = 3'h7;
   localparam logic [7:0] PRI_VEC_BASE  = 8'h08;
   localparam logic [7:0] SEC_VEC_BASE  = 8'h70;

   // request spacing, met by one-cycle edge detection
   localparam int REQ_GAP_NS  = 125;
   localparam int CLK_NS      = 10;
   localparam int REQ_GAP_CYC = (REQ_GAP_NS + CLK_NS - 1) / CLK_NS;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       rd;
      logic       wr;
   } cpic_io_req_type;

   typedef struct packed {
      logic [2:0] idx;
      logic       valid;
   } cpic_pick_type;

   typedef struct packed {
      logic [7:0] pri_mask;
      logic [7:0] sec_mask;
      logic [7:0] pri_trig;
      logic [7:0] sec_trig;
      logic [7:0] pri_isr;
      logic [7:0] sec_isr;
      logic       int_out;
      logic [7:0] vec_data;
      logic       vec_valid;
      logic [7:0] io_rdata;
   } cpic_state_type;

   // highest pending line not blocked by an equal or higher in-service
   function automatic cpic_pick_type cpic_pick(input logic [7:0] req,
                                               input logic [7:0] service_routine);
      cpic_pick_type p;
      logic          done;
      p    = '{idx: 3'h0, valid: 1'b0};
      done = 1'b0;
      for (int i = 0; i < 8; i++) begin
         // in-service blocks its own line and all below
         if (service_routine[i]) begin
            done = 1'b1;
         end
         if (!done && req[i]) begin
            p.idx   = 3'(i);
            p.valid = 1'b1;
            done    = 1'b1;
         end
      end
      return p;
   endfunction

   // clear the highest-priority in-service flag
   function automatic logic [7:0] cpic_done(input logic [7:0] service_routine);
      logic [7:0] r;
      logic       hit;
      r   = service_routine;
      hit = 1'b0;
      for (int i = 0; i < 8; i++) begin
         if (!hit && service_routine[i]) begin
            r[i] = 1'b0;
            hit  = 1'b1;
         end
      end
      return r;
   endfunction

   function automatic logic [7:0] cpic_onehot(input logic [2:0] idx);
      return 8'h01 << idx;
   endfunction

endpackage

// [design/cpic_req_capture.sv]
// Purpose: request capture for one eight-line controller
// Assumes: lines synchronous to clk
// Notes:   edge lines latch, level lines follow the pin
`timescale 1ns/10ps
module cpic_req_capture (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       sys_rst,
   // request lines and setup
   input  wire logic [7:0] lines,
   input  wire logic [7:0] mask,
   input  wire logic [7:0] level_mode,
   // acknowledge clear, one-hot
   input  wire logic [7:0] take,
   // pending requests
   output      logic [7:0] pending
);

   typedef struct packed {
      logic [7:0] prev;
      logic [7:0] latch;
   } cpic_cap_type;

   cpic_cap_type st;
   cpic_cap_type next_st;
   logic [7:0]   rise;

   always_comb begin
      next_st      = st;
      next_st.prev = lines;
      rise         = lines & ~st.prev;
      next_st.latch = (st.latch & ~take) | (rise & ~mask & ~level_mode);
   end

   assign pending = (st.latch & ~level_mode) | (lines & level_mode);

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

endmodule

// [design/cpic_top.sv]
// Purpose: cascaded pair of eight-line priority request controllers
// Assumes: I/O strobes and acknowledge are one-cycle pulses on clk
// Notes:   request_line_n bit 2 is the cascade and is ignored as input
`timescale 1ns/10ps
module cpic_top (
   // clock and reset
   input  wire logic                     clk,
   input  wire logic                     sys_rst,
   // request lines 0 to 15
   input  wire logic [15:0]              request_line_n,
   // i/o port access
   input  wire cpic_pkg::cpic_io_req_type io_req,
   output      logic [7:0]               io_rdata,
   // core interrupt and acknowledge
   output      logic                     int_out,
   input  wire logic                     int_ack,
   output      logic [7:0]               vec_data,
   output      logic                     vec_valid
);

   cpic_pkg::cpic_state_type st;
   cpic_pkg::cpic_state_type next_st;

   logic [7:0]              pri_lines;
   logic [7:0]              pri_pend;
   logic [7:0]              sec_pend;
   logic [7:0]              pri_take;
   logic [7:0]              sec_take;
   logic [7:0]              pri_req;
   logic [7:0]              sec_req;
   cpic_pkg::cpic_pick_type pri_win;
   cpic_pkg::cpic_pick_type sec_win;
   cpic_pkg::cpic_pick_type nxt_pri;
   cpic_pkg::cpic_pick_type nxt_sec;
   logic [7:0]              nxt_pri_req;

   always_comb begin
      pri_lines = request_line_n[7:0];
      pri_lines[cpic_pkg::CASCADE_LINE] = 1'b0;
   end

   cpic_req_capture u_pri_cap (
      .clk        (clk),
      .sys_rst    (sys_rst),
      .lines      (pri_lines),
      .mask       (st.pri_mask),
      .level_mode (st.pri_trig),
      .take       (pri_take),
      .pending    (pri_pend)
   );

   cpic_req_capture u_sec_cap (
      .clk        (clk),
      .sys_rst    (sys_rst),
      .lines      (request_line_n[15:8]),
      .mask       (st.sec_mask),
      .level_mode (st.sec_trig),
      .take       (sec_take),
      .pending    (sec_pend)
   );

   always_comb begin
      sec_req = sec_pend & ~st.sec_mask;
      sec_win = cpic_pkg::cpic_pick(sec_req, st.sec_isr);
      pri_req = pri_pend & ~st.pri_mask;
      pri_req[cpic_pkg::CASCADE_LINE] =
         sec_win.valid & ~st.pri_mask[cpic_pkg::CASCADE_LINE];
      pri_win = cpic_pkg::cpic_pick(pri_req, st.pri_isr);
   end

   // acknowledge clears the latched edge of the winner
   always_comb begin
      pri_take = 8'h00;
      sec_take = 8'h00;
      if (int_ack && pri_win.valid) begin
         pri_take = cpic_pkg::cpic_onehot(pri_win.idx);
         if (pri_win.idx == cpic_pkg::CASCADE_LINE) begin
            sec_take = cpic_pkg::cpic_onehot(sec_win.idx);
         end
      end
   end

   always_comb begin
      next_st           = st;
      next_st.vec_valid = 1'b0;

      if (io_req.wr) begin
         unique case (io_req.addr)
            cpic_pkg::PRI_MASK_PORT: next_st.pri_mask = io_req.wdata;
            cpic_pkg::SEC_MASK_PORT: next_st.sec_mask = io_req.wdata;
            cpic_pkg::PRI_TRIG_PORT: next_st.pri_trig = io_req.wdata;
            cpic_pkg::SEC_TRIG_PORT: next_st.sec_trig = io_req.wdata;
            cpic_pkg::PRI_CMD_PORT: begin
               if (io_req.wdata == cpic_pkg::SERVICE_DONE) begin
                  next_st.pri_isr = cpic_pkg::cpic_done(st.pri_isr);
               end
            end
            cpic_pkg::SEC_CMD_PORT: begin
               if (io_req.wdata == cpic_pkg::SERVICE_DONE) begin
                  next_st.sec_isr = cpic_pkg::cpic_done(st.sec_isr);
               end
            end
            default: ;
         endcase
      end

      if (io_req.rd) begin
         unique case (io_req.addr)
            cpic_pkg::PRI_MASK_PORT: next_st.io_rdata = st.pri_mask;
            cpic_pkg::SEC_MASK_PORT: next_st.io_rdata = st.sec_mask;
            cpic_pkg::PRI_TRIG_PORT: next_st.io_rdata = st.pri_trig;
            cpic_pkg::SEC_TRIG_PORT: next_st.io_rdata = st.sec_trig;
            cpic_pkg::PRI_CMD_PORT:  next_st.io_rdata = st.pri_isr;
            cpic_pkg::SEC_CMD_PORT:  next_st.io_rdata = st.sec_isr;
            default: next_st.io_rdata = cpic_pkg::UNMAPPED_READ;
         endcase
      end

      if (int_ack) begin
         next_st.vec_valid = 1'b1;
         if (!pri_win.valid) begin
            next_st.vec_data = cpic_pkg::PRI_VEC_BASE +
                               {5'h00, cpic_pkg::SPURIOUS_LINE};
         end else if (pri_win.idx == cpic_pkg::CASCADE_LINE) begin
            next_st.vec_data = cpic_pkg::SEC_VEC_BASE +
                               {5'h00, sec_win.idx};
            next_st.sec_isr  = next_st.sec_isr |
                               cpic_pkg::cpic_onehot(sec_win.idx);
            next_st.pri_isr  = next_st.pri_isr |
                               cpic_pkg::cpic_onehot(pri_win.idx);
         end else begin
            next_st.vec_data = cpic_pkg::PRI_VEC_BASE +
                               {5'h00, pri_win.idx};
            next_st.pri_isr  = next_st.pri_isr |
                               cpic_pkg::cpic_onehot(pri_win.idx);
         end
      end

      nxt_sec     = cpic_pkg::cpic_pick(sec_req, next_st.sec_isr);
      nxt_pri_req = pri_req & ~pri_take;
      nxt_pri_req[cpic_pkg::CASCADE_LINE] =
         nxt_sec.valid & ~st.pri_mask[cpic_pkg::CASCADE_LINE];
      nxt_pri = cpic_pkg::cpic_pick(nxt_pri_req, next_st.pri_isr);
      next_st.int_out = nxt_pri.valid & ~int_ack;
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st.pri_mask  <= cpic_pkg::MASK_RESET;
         st.sec_mask  <= cpic_pkg::MASK_RESET;
         st.pri_trig  <= cpic_pkg::TRIG_RESET;
         st.sec_trig  <= cpic_pkg::TRIG_RESET;
         st.pri_isr   <= cpic_pkg::ISR_RESET;
         st.sec_isr   <= cpic_pkg::ISR_RESET;
         st.int_out   <= 1'b0;
         st.vec_data  <= cpic_pkg::VEC_RESET;
         st.vec_valid <= 1'b0;
         st.io_rdata  <= cpic_pkg::VEC_RESET;
      end else begin
         st <= next_st;
      end
   end

   assign io_rdata  = st.io_rdata;
   assign int_out   = st.int_out;
   assign vec_data  = st.vec_data;
   assign vec_valid = st.vec_valid;

endmodule

// [verification/cpic_assertions.sv]
// Purpose: port checks of the cascaded request controller pair
// Assumes: one clock, async active-high reset
// Notes:   primary mask is shadowed from port writes
`timescale 1ns/10ps
module cpic_checker (
   // clock and reset
   input wire logic                      clk,
   input wire logic                      sys_rst,
   // i/o port
   input wire cpic_pkg::cpic_io_req_type io_req,
   input wire logic [7:0]                io_rdata,
   // core side
   input wire logic                      int_out,
   input wire logic                      int_ack,
   input wire logic [7:0]                vec_data,
   input wire logic                      vec_valid
);
   logic [7:0] mask_copy;
   logic       mapped;
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // ports 20-22h and A0-A2h
   assign mapped = io_req.addr[6:2] == 5'h08 && io_req.addr[1:0] != 2'h3;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst)
         mask_copy <= cpic_pkg::MASK_RESET;
      else if (io_req.wr && io_req.addr == cpic_pkg::PRI_MASK_PORT)
         mask_copy <= io_req.wdata;
   end
   AST_VEC_AFTER_ACK: assert property (int_ack |=> vec_valid)
      else $error("no vector after acknowledge");
   AST_VEC_CAUSE: assert property (vec_valid |-> $past(int_ack))
      else $error("vector without acknowledge");
   AST_VEC_PULSE: assert property (vec_valid |=> !vec_valid)
      else $error("vector strobe too long");
   AST_VEC_HOLD: assert property (!vec_valid |-> $stable(vec_data))
      else $error("vector changed without strobe");
   AST_VEC_CODE: assert property (vec_valid |->
      vec_data[7:3] == 5'h01 || vec_data[7:3] == 5'h0E)
      else $error("vector outside both ranges");
   AST_INT_DROP: assert property (int_ack |=> !int_out)
      else $error("interrupt kept after acknowledge");
   AST_MASK_READ: assert property (io_req.rd && !io_req.wr &&
      io_req.addr == cpic_pkg::PRI_MASK_PORT |=> io_rdata == $past(mask_copy))
      else $error("mask read wrong");
   AST_UNMAPPED: assert property (io_req.rd && !mapped |=>
      io_rdata == cpic_pkg::UNMAPPED_READ)
      else $error("unmapped read wrong");
   AST_ALL_MASKED: assert property (mask_copy == 8'hFF &&
      $past(mask_copy) == 8'hFF |-> !$rose(int_out))
      else $error("interrupt while all masked");
   AST_RST_QUIET: assert property (disable iff (1'b0)
      sys_rst |=> !int_out && !vec_valid)
      else $error("output active after reset");
   cover property (vec_valid && vec_data == 8'h71);
   cover property (int_ack ##3 int_out);
   cover property (io_req.rd && !mapped);
endmodule
bind cpic_top cpic_checker chk_u (
   .clk(clk), .sys_rst(sys_rst), .io_req(io_req), .io_rdata(io_rdata),
   .int_out(int_out), .int_ack(int_ack), .vec_data(vec_data),
   .vec_valid(vec_valid));

// [verification/cpic_core_model.sv]
// Purpose: core that acknowledges interrupts and takes vectors
// Assumes: acknowledge is a one-cycle pulse
// Notes:   slow sets cycles waited before acknowledging
`timescale 1ns/10ps
module cpic_core_model (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       sys_rst,
   // controller side
   input  wire logic       int_out,
   input  wire logic       vec_valid,
   input  wire logic [7:0] vec_data,
   output      logic       int_ack,
   // bench side
   input  wire logic [3:0] slow,
   output      logic [7:0] got,
   output      logic [7:0] n_vec
);
   logic       busy;
   logic [3:0] cnt;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         int_ack <= 1'b0;
         busy <= 1'b0;
         cnt <= 4'h0;
         got <= 8'h00;
         n_vec <= 8'h00;
      end else begin
         int_ack <= 1'b0;
         if (vec_valid) begin
            got <= vec_data;
            n_vec <= n_vec + 8'h01;
            busy <= 1'b0;
         end else if (int_out && !busy && cnt == slow) begin
            int_ack <= 1'b1;
            busy <= 1'b1;
            cnt <= 4'h0;
         end else if (int_out && !busy) begin
            cnt <= cnt + 4'h1;
         end
      end
   end
endmodule

// [verification/testbench.sv]
// Purpose: self-checking bench of the controller pair
// Assumes: core model acknowledges every interrupt
// Notes:   service done is written by the bench
`timescale 1ns/10ps
module testbench;
   logic                      clk;
   logic                      sys_rst;
   logic [15:0]               lines;
   cpic_pkg::cpic_io_req_type io_req;
   logic [7:0]                io_rdata;
   logic                      int_out;
   logic                      int_ack;
   logic [7:0]                vec_data;
   logic                      vec_valid;
   logic [3:0]                slow;
   logic [7:0]                got;
   logic [7:0]                n_vec;
   logic [7:0]                n_exp;
   int                        n_errors;
   int                        checks;
   cpic_top dut_u (.clk(clk), .sys_rst(sys_rst), .request_line_n(lines),
      .io_req(io_req), .io_rdata(io_rdata), .int_out(int_out),
      .int_ack(int_ack), .vec_data(vec_data), .vec_valid(vec_valid));
   cpic_core_model core_u (.clk(clk), .sys_rst(sys_rst), .int_out(int_out),
      .vec_valid(vec_valid), .vec_data(vec_data), .int_ack(int_ack),
      .slow(slow), .got(got), .n_vec(n_vec));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic close_out;
      if (n_errors == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic io_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      io_req <= '{a, d, 1'b0, 1'b1};
      @(posedge clk);
      io_req <= '0;
   endtask
   task automatic io_rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      io_req <= '{a, 8'h00, 1'b1, 1'b0};
      @(posedge clk);
      io_req <= '0;
      #1 chk(io_rdata, exp);
   endtask
   task automatic pulse(input int l);
      @(posedge clk);
      lines <= lines | (16'h0001 << l);
      repeat (6) @(posedge clk);
      lines <= lines & ~(16'h0001 << l);
      repeat (7) @(posedge clk);
   endtask
   task automatic wait_vec(input logic [7:0] exp);
      n_exp = n_exp + 8'h01;
      for (int k = 0; k < 200 && n_vec != n_exp; k++)
         @(posedge clk);
      #1 chk(n_vec, n_exp);
      chk(got, exp);
   endtask
   task automatic wait_none;
      repeat (20) @(posedge clk);
      #1 chk(n_vec, n_exp);
   endtask
   task automatic t_reset;
      io_rd(8'h21, 8'hFF);
      io_rd(8'h20, 8'h00);
      io_rd(8'h30, 8'hFF);
      wait_none;
   endtask
   task automatic t_mask;
      io_wr(8'h21, 8'h5A);
      io_rd(8'h21, 8'h5A);
      io_wr(8'h21, 8'hDF);
      pulse(6);
      wait_none;
      pulse(5);
      wait_vec(8'h0D);
      io_rd(8'h20, 8'h20);
      io_wr(8'h20, cpic_pkg::SERVICE_DONE);
      io_rd(8'h20, 8'h00);
   endtask
   task automatic t_prio;
      io_wr(8'h21, 8'hB7);
      @(posedge clk);
      lines <= lines | 16'h0048;
      wait_vec(8'h0B);
      wait_none;
      io_wr(8'h20, cpic_pkg::SERVICE_DONE);
      wait_vec(8'h0E);
      io_wr(8'h20, cpic_pkg::SERVICE_DONE);
      lines <= lines & ~16'h0048;
   endtask
   task automatic t_nest;
      io_wr(8'h21, 8'hBD);
      pulse(6);
      wait_vec(8'h0E);
      pulse(1);
      wait_vec(8'h09);
      io_rd(8'h20, 8'h42);
      io_wr(8'h20, cpic_pkg::SERVICE_DONE);
      io_wr(8'h20, cpic_pkg::SERVICE_DONE);
      io_rd(8'h20, 8'h00);
   endtask
   task automatic t_level;
      io_wr(8'h22, 8'h10);
      io_rd(8'h22, 8'h10);
      io_wr(8'h21, 8'hEF);
      lines <= lines | 16'h0010;
      wait_vec(8'h0C);
      wait_none;
      io_wr(8'h20, cpic_pkg::SERVICE_DONE);
      wait_vec(8'h0C);
      @(posedge clk);
      lines <= lines & ~16'h0010;
      io_wr(8'h20, cpic_pkg::SERVICE_DONE);
      wait_none;
   endtask
   task automatic t_space;
      slow <= 4'h5;
      io_wr(8'h21, 8'hDF);
      pulse(5);
      pulse(5);
      wait_vec(8'h0D);
      wait_none;
      io_wr(8'h20, cpic_pkg::SERVICE_DONE);
      wait_vec(8'h0D);
      io_wr(8'h20, cpic_pkg::SERVICE_DONE);
   endtask
   task automatic t_sec;
      io_wr(8'h21, 8'hFB);
      io_wr(8'hA1, 8'hFD);
      io_rd(8'hA1, 8'hFD);
      io_wr(8'hA2, 8'h08);
      io_rd(8'hA2, 8'h08);
      pulse(9);
      wait_vec(8'h71);
      io_rd(8'h20, 8'h04);
      io_rd(8'hA0, 8'h02);
      io_wr(8'hA0, cpic_pkg::SERVICE_DONE);
      io_wr(8'h20, cpic_pkg::SERVICE_DONE);
      io_rd(8'hA0, 8'h00);
      io_rd(8'h20, 8'h00);
   endtask
   initial begin
      sys_rst = 1'b1;
      lines = '0;
      io_req = '0;
      slow = 4'h0;
      n_exp = 8'h00;
      n_errors = 0;
      checks = 0;
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
      t_reset;
      t_mask;
      t_prio;
      t_nest;
      t_level;
      t_space;
      t_sec;
      close_out;
   end
   // about thirty times the expected run
   initial begin
      #100000;
      n_errors++;
      close_out;
   end
endmodule
